//--- shared/vsbl_map.svh
`ifndef VSBL_MAP_SVH
`define VSBL_MAP_SVH
`define VSBL_CLK_HZ        100000000
`define VSBL_BAUD_DEFAULT  115200
`define VSBL_BAUD_MIN      9600
`define VSBL_BAUD_MAX      921600
`define VSBL_DATA_BITS     8
`define VSBL_PATH_PORT     4901
`define VSBL_DIV_W         16
`endif

//--- shared/vsbl_pkg.sv
package vsbl_pkg;
  typedef enum logic [2:0] {
    VSBL_HS_DISABLE,
    VSBL_HS_RTS,
    VSBL_HS_CTS,
    VSBL_HS_RTSCTS,
    VSBL_HS_AUTO
  } vsbl_hs_type;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } vsbl_byte_type;

  typedef enum logic [1:0] {
    VSBL_PATH_NONE,
    VSBL_PATH_USB,
    VSBL_PATH_SOCK
  } vsbl_path_type;
endpackage

//--- hdl/vsbl_rx.sv
`timescale 1ns/1ns
`include "vsbl_map.svh"
module vsbl_rx #(
  parameter int DIV_W = `VSBL_DIV_W
) (
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Configuration.
  input  wire logic [DIV_W-1:0]      bit_div,
  // Line, already synchronised.
  input  wire logic                  line_in,
  // Received byte.
  output vsbl_pkg::vsbl_byte_type    rx_out
);
  // Below 14 bits the slowest rate no longer fits the divider.
  if (DIV_W < 14 || DIV_W > 24) begin : g_div_check
    $error("DIV_W out of range");
  end

  typedef enum logic [1:0] {IDLE, START, DATA, STOP} vsbl_rx_state_type;
  vsbl_rx_state_type  state_reg;
  logic [DIV_W-1:0]   cnt_reg;
  logic [2:0]         bit_reg;
  logic [7:0]         sh_reg;

  // Sampling at mid bit keeps margin against rate mismatch on both edges.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      cnt_reg   <= '0;
      bit_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      rx_out    <= '0;
    end else begin
      rx_out.valid <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (!line_in) begin
            state_reg <= START;
            cnt_reg   <= bit_div >> 1;
          end
        end
        START: begin
          if (cnt_reg == '0) begin
            state_reg <= line_in ? IDLE : DATA;
            cnt_reg   <= bit_div;
            bit_reg   <= 3'h0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        DATA: begin
          if (cnt_reg == '0) begin
            sh_reg  <= {line_in, sh_reg[7:1]};
            cnt_reg <= bit_div;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_reg <= STOP;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        STOP: begin
          if (cnt_reg == '0) begin
            state_reg <= IDLE;
            if (line_in) begin
              rx_out.data  <= sh_reg;
              rx_out.valid <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end
endmodule

//--- hdl/vsbl_bridge.sv
`timescale 1ns/1ns
`include "vsbl_map.svh"
module vsbl_bridge #(
  parameter int DIV_W = `VSBL_DIV_W
) (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Configuration.
  input  wire logic [19:0]             baud_sel,
  input  wire vsbl_pkg::vsbl_hs_type   hs_mode,
  // Host paths.
  input  wire logic                    sock_connected,
  input  wire vsbl_pkg::vsbl_byte_type usb_tx_in,
  input  wire vsbl_pkg::vsbl_byte_type sock_tx_in,
  output logic                         host_tx_ready,
  output vsbl_pkg::vsbl_byte_type      usb_rx_out,
  output vsbl_pkg::vsbl_byte_type      sock_rx_out,
  input  wire logic                    host_rx_ready,
  output vsbl_pkg::vsbl_path_type      active_path,
  // Target pins.
  input  wire logic                    tgt_tx_pin,
  output logic                         tgt_rx_pin,
  output logic                         tgt_may_send_out,
  output logic                         tgt_may_send_oe,
  input  wire logic                    tgt_can_accept_pin,
  input  wire logic                    tgt_enable_pin
);
  localparam int CLK_HZ = `VSBL_CLK_HZ;

  // Below 14 bits the slowest rate no longer fits the divider.
  if (DIV_W < 14 || DIV_W > 24) begin : g_div_check
    $error("DIV_W out of range");
  end

  // Three-stage synchronisers; a change counts once stages two and three agree.
  logic [2:0] sy_tx_reg;
  logic [2:0] sy_cts_reg;
  logic [2:0] sy_en_reg;
  logic       line_tx_reg;
  logic       can_acc_reg;
  logic       enable_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sy_tx_reg  <= 3'h7;
      sy_cts_reg <= 3'h0;
      sy_en_reg  <= 3'h0;
    end else begin
      sy_tx_reg  <= {sy_tx_reg[1:0], tgt_tx_pin};
      sy_cts_reg <= {sy_cts_reg[1:0], tgt_can_accept_pin};
      sy_en_reg  <= {sy_en_reg[1:0], tgt_enable_pin};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_tx_reg <= 1'b1;
      can_acc_reg <= 1'b0;
      enable_reg  <= 1'b0;
    end else begin
      if (sy_tx_reg[1] == sy_tx_reg[2]) line_tx_reg <= sy_tx_reg[2];
      if (sy_cts_reg[1] == sy_cts_reg[2]) can_acc_reg <= sy_cts_reg[2];
      if (sy_en_reg[1] == sy_en_reg[2]) enable_reg <= sy_en_reg[2];
    end
  end

  // Rate clamp and divider.
  logic [19:0]      baud_eff;
  logic [DIV_W-1:0] bit_div_reg;
  always_comb begin
    if (baud_sel == 20'h0) begin
      baud_eff = 20'(`VSBL_BAUD_DEFAULT);
    end else if (baud_sel < 20'(`VSBL_BAUD_MIN)) begin
      baud_eff = 20'(`VSBL_BAUD_MIN);
    end else if (baud_sel > 20'(`VSBL_BAUD_MAX)) begin
      baud_eff = 20'(`VSBL_BAUD_MAX);
    end else begin
      baud_eff = baud_sel;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_div_reg <= DIV_W'(CLK_HZ / `VSBL_BAUD_DEFAULT - 1);
    end else begin
      bit_div_reg <= DIV_W'(CLK_HZ / 32'(baud_eff) - 1);
    end
  end

  // Handshake decode; auto behaves as both lines enabled.
  logic rts_en;
  logic cts_en;
  always_comb begin
    rts_en = 1'b0;
    cts_en = 1'b0;
    case (hs_mode)
      vsbl_pkg::VSBL_HS_RTS:    rts_en = 1'b1;
      vsbl_pkg::VSBL_HS_CTS:    cts_en = 1'b1;
      vsbl_pkg::VSBL_HS_RTSCTS,
      vsbl_pkg::VSBL_HS_AUTO: begin
        rts_en = 1'b1;
        cts_en = 1'b1;
      end
      default: ;
    endcase
  end

  // Path selection: the socket always takes priority.
  always_comb begin
    if (sock_connected) begin
      active_path = vsbl_pkg::VSBL_PATH_SOCK;
    end else begin
      active_path = vsbl_pkg::VSBL_PATH_USB;
    end
  end

  vsbl_pkg::vsbl_byte_type host_byte;
  assign host_byte = sock_connected ? sock_tx_in : usb_tx_in;

  // Receiver for target data.
  vsbl_pkg::vsbl_byte_type rx_byte;
  vsbl_rx #(.DIV_W(DIV_W)) u_rx (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .bit_div (bit_div_reg),
    .line_in (line_tx_reg),
    .rx_out  (rx_byte)
  );

  // One-byte hold toward the host; its fullness drives target-may-send.
  vsbl_pkg::vsbl_byte_type hold_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= '0;
    end else begin
      if (rx_byte.valid && enable_reg) begin
        hold_reg <= rx_byte;
      end else if (host_rx_ready) begin
        hold_reg.valid <= 1'b0;
      end
    end
  end

  always_comb begin
    usb_rx_out  = hold_reg;
    sock_rx_out = hold_reg;
    usb_rx_out.valid  = hold_reg.valid && !sock_connected;
    sock_rx_out.valid = hold_reg.valid && sock_connected;
  end

  // Released unless the mode uses RTS (RTS, RTS/CTS, auto), so the pin floats as an unused handshake.
  assign tgt_may_send_oe  = rts_en;
  assign tgt_may_send_out = !hold_reg.valid && enable_reg;

  // Transmitter toward the target.
  typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} vsbl_tx_type;
  vsbl_tx_type      tx_state_reg;
  logic [DIV_W-1:0] tx_cnt_reg;
  logic [2:0]       tx_bit_reg;
  logic [7:0]       tx_sh_reg;
  logic             tx_go;

  assign tx_go = (tx_state_reg == T_IDLE) && enable_reg
                 && (can_acc_reg || !cts_en);
  assign host_tx_ready = tx_go;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= T_IDLE;
      tx_cnt_reg   <= '0;
      tx_bit_reg   <= 3'h0;
      tx_sh_reg    <= 8'h00;
      tgt_rx_pin   <= 1'b1;
    end else begin
      case (tx_state_reg)
        T_IDLE: begin
          tgt_rx_pin <= 1'b1;
          if (tx_go && host_byte.valid) begin
            tx_sh_reg    <= host_byte.data;
            tx_cnt_reg   <= bit_div_reg;
            tx_state_reg <= T_START;
            tgt_rx_pin   <= 1'b0;
          end
        end
        T_START, T_DATA: begin
          if (tx_cnt_reg == '0) begin
            tx_cnt_reg <= bit_div_reg;
            if (tx_state_reg == T_START) begin
              tx_bit_reg   <= 3'h0;
              tx_state_reg <= T_DATA;
              tgt_rx_pin   <= tx_sh_reg[0];
            end else if (tx_bit_reg == 3'h7) begin
              tx_state_reg <= T_STOP;
              tgt_rx_pin   <= 1'b1;
            end else begin
              tx_bit_reg <= tx_bit_reg + 3'h1;
              tgt_rx_pin <= tx_sh_reg[3'(tx_bit_reg + 3'h1)];
            end
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end
        end
        T_STOP: begin
          // A halt from the target never cuts the character short.
          if (tx_cnt_reg == '0) begin
            tx_state_reg <= T_IDLE;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end
        end
        default: tx_state_reg <= T_IDLE;
      endcase
    end
  end

  property no_tx_disabled;
    @(posedge mclk) disable iff (!rst_n)
      (tx_state_reg == T_IDLE && !enable_reg) |=> tx_state_reg == T_IDLE;
  endproperty
  tx_gate_enable_a: assert property (no_tx_disabled)
    else $error("transmit started while link disabled");

  halt_flow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (tx_state_reg == T_IDLE && cts_en && !can_acc_reg)
      |=> tx_state_reg == T_IDLE)
    else $error("transmit started while target halted");

  ignore_flow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (tx_state_reg == T_IDLE && !cts_en && enable_reg && host_byte.valid)
      |=> tx_state_reg == T_START)
    else $error("byte held back with flow control off");

  start_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (tx_state_reg == T_START) |-> !tgt_rx_pin)
    else $error("start bit not low");

  stop_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (tx_state_reg == T_STOP) |-> tgt_rx_pin)
    else $error("stop bit not high");

  may_send_a: assert property (@(posedge mclk) disable iff (!rst_n)
      hold_reg.valid |-> !tgt_may_send_out)
    else $error("target allowed to send with full hold");

  one_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(usb_rx_out.valid && sock_rx_out.valid))
    else $error("both host paths active");

  sock_prio_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sock_connected |-> active_path == vsbl_pkg::VSBL_PATH_SOCK)
    else $error("socket does not take priority");

  rts_oe_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tgt_may_send_oe == rts_en)
    else $error("target-may-send drive does not follow mode");

  rate_min_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bit_div_reg <= DIV_W'(CLK_HZ / `VSBL_BAUD_MIN - 1))
    else $error("bit rate below minimum");

  sequence tx_launch_s;
    tx_state_reg == T_IDLE && tx_go && host_byte.valid;
  endsequence
  sequence start_bit_s;
    tx_state_reg == T_START && !tgt_rx_pin;
  endsequence
  launch_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tx_launch_s |=> start_bit_s)
    else $error("start bit not launched");
endmodule

//--- verification/vsbl_target_model.sv
`timescale 1ns/1ns
module vsbl_target_model (
  // Timing.
  input  wire logic        mclk,
  input  wire logic [15:0] bit_cyc,
  // Serial pins.
  output logic             tx_line,
  input  wire logic        rx_line,
  output logic             can_accept,
  output logic             enable
);
  logic [7:0] rx_byte;
  logic       stop_ok;
  int         rx_count;

  initial begin
    tx_line = 1'b1;
    can_accept = 1'b1;
    enable = 1'b0;
    rx_count = 0;
  end

  // Flow control and enable levels are the target's to drive.
  task automatic set_link(input logic en, input logic acc);
    enable = en;
    can_accept = acc;
  endtask

  // Whole frame, LSB first, line left high afterwards.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_line = f[i];
      repeat (bit_cyc) begin
        @(posedge mclk);
        #1;
      end
    end
  endtask

  // Mid-bit sampling, so a wrong bit period corrupts the byte.
  always begin
    @(negedge rx_line);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge mclk);
      if (i < 8) begin
        rx_byte[i] = rx_line;
      end else begin
        stop_ok = rx_line;
      end
    end
    rx_count++;
  end
endmodule

//--- verification/vsbl_bridge_tb.sv
`timescale 1ns/1ns
module vsbl_bridge_tb;
  typedef struct {
    logic [19:0]           baud;
    vsbl_pkg::vsbl_hs_type hs;
    logic                  sock;
    logic [7:0]            d;
    logic [15:0]           cyc;
  } vsbl_row_type;

  logic                    mclk;
  logic                    rst_n;
  logic [19:0]             baud_sel;
  vsbl_pkg::vsbl_hs_type   hs_mode;
  logic                    sock_connected;
  vsbl_pkg::vsbl_byte_type usb_tx_in;
  vsbl_pkg::vsbl_byte_type sock_tx_in;
  logic                    host_tx_ready;
  vsbl_pkg::vsbl_byte_type usb_rx_out;
  vsbl_pkg::vsbl_byte_type sock_rx_out;
  logic                    host_rx_ready;
  vsbl_pkg::vsbl_path_type active_path;
  logic                    tx_pin;
  logic                    rx_pin;
  logic                    may_send;
  logic                    may_oe;
  logic                    can_acc;
  logic                    enable;
  logic [15:0]             bit_cyc;
  int                      fails;
  int                      checked;
  int                      c0;
  vsbl_row_type            rows [5];

  vsbl_bridge dut_u (.mclk(mclk), .rst_n(rst_n), .baud_sel(baud_sel),
    .hs_mode(hs_mode), .sock_connected(sock_connected),
    .usb_tx_in(usb_tx_in), .sock_tx_in(sock_tx_in),
    .host_tx_ready(host_tx_ready), .usb_rx_out(usb_rx_out),
    .sock_rx_out(sock_rx_out), .host_rx_ready(host_rx_ready),
    .active_path(active_path), .tgt_tx_pin(tx_pin), .tgt_rx_pin(rx_pin),
    .tgt_may_send_out(may_send), .tgt_may_send_oe(may_oe),
    .tgt_can_accept_pin(can_acc), .tgt_enable_pin(enable));

  vsbl_target_model tgt_u (.mclk(mclk), .bit_cyc(bit_cyc),
    .tx_line(tx_pin), .rx_line(rx_pin), .can_accept(can_acc),
    .enable(enable));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Ready does not depend on valid, so valid is raised only once ready.
  task automatic host_send(input logic s, input logic [7:0] b);
    int n;
    n = 0;
    while (host_tx_ready !== 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    chk("ready wait", 1, host_tx_ready);
    if (s) sock_tx_in = '{b, 1'b1};
    else usb_tx_in = '{b, 1'b1};
    tick(1);
    usb_tx_in.valid = 1'b0;
    sock_tx_in.valid = 1'b0;
  endtask

  task automatic wait_tgt(input int c);
    int n;
    n = 0;
    while (tgt_u.rx_count == c && n < 20000) begin
      tick(1);
      n++;
    end
    chk("frame wait", 1, tgt_u.rx_count != c);
  endtask

  task automatic host_recv(input logic s, input logic [7:0] b);
    int n;
    n = 0;
    while ((s ? sock_rx_out.valid : usb_rx_out.valid) !== 1'b1 &&
           n < 400) begin
      tick(1);
      n++;
    end
    chk("rx valid", 1, s ? sock_rx_out.valid : usb_rx_out.valid);
    chk("rx data", b, s ? sock_rx_out.data : usb_rx_out.data);
    chk("idle path", 0, s ? usb_rx_out.valid : sock_rx_out.valid);
    chk("may send full", 0, may_send);
    host_rx_ready = 1'b1;
    tick(1);
    host_rx_ready = 1'b0;
    tick(2);
    chk("may send empty", 1, may_send);
  endtask

  task automatic complete_run();
    $display("Counts: checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    complete_run();
  end

  initial begin
    rows = '{'{20'h00000, vsbl_pkg::VSBL_HS_DISABLE, 1'b0, 8'hA5, 16'h0364},
      '{20'hFFFFF, vsbl_pkg::VSBL_HS_RTS, 1'b1, 8'h3C, 16'h006C},
      '{20'h38400, vsbl_pkg::VSBL_HS_CTS, 1'b0, 8'h81, 16'h01B2},
      '{20'h70800, vsbl_pkg::VSBL_HS_RTSCTS, 1'b1, 8'h7E, 16'h00D9},
      '{20'hE1000, vsbl_pkg::VSBL_HS_AUTO, 1'b0, 8'h01, 16'h006C}};
    fails = 0;
    checked = 0;
    rst_n = 1'b0;
    baud_sel = 20'h00000;
    hs_mode = vsbl_pkg::VSBL_HS_DISABLE;
    sock_connected = 1'b0;
    usb_tx_in = '0;
    sock_tx_in = '0;
    host_rx_ready = 1'b0;
    bit_cyc = 16'h0364;
    tick(16);
    chk("reset line", 1, rx_pin);
    chk("reset valid", 0, usb_rx_out.valid);
    $display("reset test done");
    tgt_u.set_link(1'b1, 1'b1);
    rst_n = 1'b1;
    tick(8);
    foreach (rows[i]) begin
      baud_sel = rows[i].baud;
      hs_mode = rows[i].hs;
      sock_connected = rows[i].sock;
      bit_cyc = rows[i].cyc;
      tick(4);
      chk("path", rows[i].sock ? vsbl_pkg::VSBL_PATH_SOCK
        : vsbl_pkg::VSBL_PATH_USB, active_path);
      chk("oe", rows[i].hs inside {vsbl_pkg::VSBL_HS_RTS,
        vsbl_pkg::VSBL_HS_RTSCTS, vsbl_pkg::VSBL_HS_AUTO}, may_oe);
      c0 = tgt_u.rx_count;
      host_send(rows[i].sock, rows[i].d);
      wait_tgt(c0);
      chk("tx data", rows[i].d, tgt_u.rx_byte);
      chk("tx stop", 1, tgt_u.stop_ok);
      tgt_u.send_byte(~rows[i].d);
      host_recv(rows[i].sock, ~rows[i].d);
      $display("row %0d done", i);
    end
    sock_connected = 1'b0;
    tgt_u.set_link(1'b0, 1'b1);
    tick(8);
    chk("disabled ready", 0, host_tx_ready);
    tgt_u.send_byte(8'h55);
    tick(40);
    chk("disabled rx", 0, usb_rx_out.valid);
    tgt_u.set_link(1'b1, 1'b1);
    $display("enable test done");
    hs_mode = vsbl_pkg::VSBL_HS_CTS;
    tick(8);
    c0 = tgt_u.rx_count;
    host_send(1'b0, 8'h96);
    tick(5);
    tgt_u.set_link(1'b1, 1'b0);
    wait_tgt(c0);
    chk("last char", 8'h96, tgt_u.rx_byte);
    tick(4);
    chk("halted ready", 0, host_tx_ready);
    hs_mode = vsbl_pkg::VSBL_HS_DISABLE;
    tick(2);
    c0 = tgt_u.rx_count;
    host_send(1'b0, 8'hC3);
    wait_tgt(c0);
    chk("ignored cts", 8'hC3, tgt_u.rx_byte);
    $display("flow control test done");
    // Too slow for a whole frame in the run, so bit lengths are timed.
    baud_sel = 20'h00001;
    bit_cyc = 16'h28B0;
    tick(2);
    host_send(1'b0, 8'h01);
    tick(10414);
    chk("slow start", 0, rx_pin);
    tick(2);
    chk("slow bit 0", 1, rx_pin);
    tick(10416);
    chk("slow bit 1", 0, rx_pin);
    $display("low rate test done");
    rst_n = 1'b0;
    tick(2);
    chk("mid reset line", 1, rx_pin);
    chk("mid reset ready", 0, host_tx_ready);
    chk("mid reset send", 0, may_send);
    rst_n = 1'b1;
    tick(8);
    chk("after reset ready", 1, host_tx_ready);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule
